// ==== logic/ecio_top.sv ====
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Overvoltage or overcurrent kills output and display
// - Power unit fault kills output and display
// - Control fault kills all, halts until power-off
// - Disabled mode ignores inputs, status still driven
// - Modes: disabled, enabled, peripheral control
// - Status outputs always driven
// - Sample inputs and update outputs each tick
// - Remote state ignores all control inputs
// - Falling edges switch output off or on
// - Sequence edges: start, stop, hold, branches
// - Start and stop also drive simulation
// - Two select bits pick memory; recall edge
// - Recall memory follows output function mode
// - Peak-clear edge resets held peak
// - Output and calibration state follow polarity
// - Protection line low active when negative
// - Busy line low busy when negative
// - Range line ignores polarity
// - One polarity inverts five status lines, trigger has its own; default negative
// - Step sync driven by sequence or simulation
module ecio_top #(
  parameter int TICK_CYC = ecio_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Fault inputs
  input  wire logic                 fault_ovoc,
  input  wire logic                 fault_unit,
  input  wire logic                 fault_ctrl,
  // Control port pins
  input  wire ecio_pkg::ecio_cmd_t  cmd_in_n,
  input  wire logic [1:0]           mem_sel,
  output ecio_pkg::ecio_stat_t      stat_out,
  // Device actions
  output logic                      output_on,
  output logic                      display_on,
  output logic                      halted,
  output logic                      peripheral_control_mode,
  output logic [ecio_pkg::CMD_W-1:0] cmd_pulse,
  output logic [1:0]                recall_mem,
  output logic [1:0]                recall_func,
  output logic                      recall_compile
);
  import ecio_pkg::*;

  initial begin
    if (TICK_CYC < 2) $error("TICK_CYC too small");
    if (CMD_W != $bits(ecio_cmd_t)) $error("CMD_W does not match the command struct");
  end

  logic [CTRL_WIDTH-1:0] ctrl_q, ctrl_d;
  logic [31:0]           tick_cnt_q;
  logic                  tick;
  ecio_cmd_t             samp_q;
  ecio_cmd_t             fall;
  logic [CMD_W-1:0]      pulse_q;
  logic [1:0]            rmem_q;
  logic [1:0]            rfunc_q;
  logic                  rcomp_q;
  logic                  out_on_q;
  logic                  halt_q;
  logic                  disp_q;
  logic                  prot_q;
  ecio_stat_t            stat_q, stat_d;
  logic                  sw_on_q, sw_off_q;

  // APB decode; single-cycle answer, unmapped addresses error
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire hit_ctrl = paddr == ECIO_CTRL_OFF;
  wire hit_stat = paddr == ECIO_STAT_OFF;
  wire hit_cmd  = paddr == ECIO_CMD_OFF;
  wire hit_in   = paddr == ECIO_INPUT_OFF;
  wire mapped   = hit_ctrl | hit_stat | hit_cmd | hit_in;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  wire [31:0] stat_word = {20'h0, halt_q, prot_q, out_on_q, disp_q, stat_q[7:0]};
  assign prdata = hit_ctrl ? {18'h0, ctrl_q} :
                  hit_stat ? stat_word :
                  hit_in   ? {21'h0, mem_sel, samp_q} : 32'h0;

  wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [31:0] wmerged = ({18'h0, ctrl_q} & ~wmask) | (pwdata & wmask);
  assign ctrl_d = (wr & hit_ctrl) ? wmerged[CTRL_WIDTH-1:0] : ctrl_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= CTRL_RST;
    else ctrl_q <= ctrl_d;
  end

  // Software panel on/off requests, command register bit0 on, bit1 off
  wire sw_on  = wr & hit_cmd & pstrb[0] & pwdata[0];
  wire sw_off = wr & hit_cmd & pstrb[0] & pwdata[1];

  // Fixed sampling tick
  assign tick = tick_cnt_q == 32'(TICK_CYC - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt_q <= 32'h0;
    else tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
  end

  wire ecio_mode_t mode = ecio_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  wire remote  = ctrl_q[CTRL_REM_BIT];
  // Peripheral mode and remote state both mask the control port
  wire inputs_live = (mode == ECIO_MODE_ENABLED) & ~remote & ~halt_q;
  assign peripheral_control_mode = mode == ECIO_MODE_PERIPH;

  // Inputs idle high (pulled up), so reset sample is all ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) samp_q <= ecio_cmd_t'('1);
    else if (tick) samp_q <= cmd_in_n;
  end
  assign fall = samp_q & ~cmd_in_n;

  wire [1:0] func = ctrl_q[CTRL_FUNC_LSB +: 2];
  wire seqlike = (func == FUNC_SEQ) | (func == FUNC_SIM);
  logic [CMD_W-1:0] pulse_d;
  always_comb begin
    pulse_d = '0;
    if (tick & inputs_live) begin
      pulse_d = fall;
      // Sequence commands only mean something in sequence or simulation
      if (!seqlike) pulse_d[6:2] = 5'h0;
      if (!(func == FUNC_SEQ)) pulse_d[6:5] = 2'h0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pulse_q <= '0;
    else pulse_q <= pulse_d;
  end
  assign cmd_pulse = pulse_q;

  // Recall target sampled with the edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rmem_q  <= 2'h0;
      rfunc_q <= 2'h0;
      rcomp_q <= 1'b0;
    end else if (pulse_d[7]) begin
      rmem_q  <= mem_sel;
      rfunc_q <= func;
      rcomp_q <= seqlike;
    end
  end
  assign recall_mem     = rmem_q;
  assign recall_func    = rfunc_q;
  assign recall_compile = rcomp_q;

  // Protection: any fault forces off; control fault latches halt
  wire any_fault = fault_ovoc | fault_unit | fault_ctrl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_on_q <= 1'b0;
      disp_q   <= 1'b1;
      halt_q   <= 1'b0;
      prot_q   <= 1'b0;
    end else begin
      if (fault_ctrl) halt_q <= 1'b1;
      prot_q <= any_fault | halt_q;
      if (any_fault | halt_q) begin
        out_on_q <= 1'b0;
        disp_q   <= 1'b0;
      end else if (pulse_d[0] | sw_off) out_on_q <= 1'b0;
      else if (pulse_d[1] | sw_on) out_on_q <= 1'b1;
    end
  end
  assign output_on  = out_on_q;
  assign display_on = disp_q;
  assign halted     = halt_q;

  // Status pins refreshed on the tick; polarity bit 0 means negative
  wire pol  = ctrl_q[CTRL_POL_BIT];
  wire tpol = ctrl_q[CTRL_TPOL_BIT];
  always_comb begin
    stat_d              = stat_q;
    stat_d.output_state = ~(out_on_q ^ pol);
    stat_d.agc_cal      = ~(ctrl_q[CTRL_AGC_BIT] ^ pol);
    stat_d.protect      = ~(prot_q ^ pol);
    stat_d.limiter      = ~(ctrl_q[CTRL_LIM_BIT] ^ pol);
    stat_d.busy         = ~(ctrl_q[CTRL_BUSY_BIT] ^ pol);
    stat_d.range        = ctrl_q[CTRL_R100_BIT];
    stat_d.step_sync1   = seqlike & ctrl_q[CTRL_SYNC_LSB];
    stat_d.step_sync2   = seqlike & ctrl_q[CTRL_SYNC_LSB+1];
    stat_d.trigger      = ~(ctrl_q[CTRL_TRIG_BIT] ^ tpol);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stat_q <= ecio_stat_t'(9'h0FF);
    else if (tick) stat_q <= stat_d;
  end
  assign stat_out = stat_q;

  // Protection and command gating
  chk_halt_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    halt_q |=> halt_q)
    else $error("halt cleared");
  chk_fault_kills_out: assert property (
    @(posedge pclk) disable iff (!presetn)
    any_fault |=> !out_on_q && !disp_q)
    else $error("output on during fault");
  chk_unit_fault_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_unit |=> !out_on_q)
    else $error("unit fault left output on");
  chk_no_cmd_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    !inputs_live |=> pulse_q == '0)
    else $error("command while gated");
  chk_remote_ignore: assert property (
    @(posedge pclk) disable iff (!presetn)
    remote |=> pulse_q == '0)
    else $error("command in remote");
  chk_pulse_on_tick: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pulse_q != '0) |-> $past(tick))
    else $error("command off tick");
  chk_range_fixed: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(tick) |-> stat_out.range == $past(ctrl_q[CTRL_R100_BIT]))
    else $error("range wrong");
  chk_out_pol: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(tick) |-> stat_out.output_state == ~($past(out_on_q) ^ $past(pol)))
    else $error("output pol");
  chk_recall_sel: assert property (
    @(posedge pclk) disable iff (!presetn)
    pulse_d[7] |=> recall_mem == $past(mem_sel))
    else $error("recall select");

  // Bus side
  chk_pready_zero_wait: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel |-> pready)
    else $error("wait state inserted");
  chk_slverr_unmapped: assert property (
    @(posedge pclk) disable iff (!presetn)
    (acc && !mapped) |-> pslverr)
    else $error("no error on unmapped access");
  chk_slverr_mapped: assert property (
    @(posedge pclk) disable iff (!presetn)
    (acc && mapped) |-> !pslverr)
    else $error("error on mapped access");
  chk_ctrl_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && hit_ctrl && pstrb == 4'hF) |=> ctrl_q == $past(pwdata[CTRL_WIDTH-1:0]))
    else $error("control write lost");
  chk_ctrl_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr && hit_ctrl) |=> ctrl_q == $past(ctrl_q))
    else $error("control changed without write");
  // Sampling tick
  chk_tick_wrap: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick |=> tick_cnt_q == 32'h0)
    else $error("tick counter did not wrap");
  chk_tick_count: assert property (
    @(posedge pclk) disable iff (!presetn)
    !tick |=> tick_cnt_q == $past(tick_cnt_q) + 32'h1)
    else $error("tick counter skipped");
  chk_tick_bound: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick_cnt_q < 32'(TICK_CYC))
    else $error("tick counter out of range");
  chk_samp_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !tick |=> samp_q == $past(samp_q))
    else $error("sample moved off tick");
  chk_samp_take: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick |=> samp_q == $past(cmd_in_n))
    else $error("sample not taken on tick");
  chk_pulse_edge: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pulse_q != '0) |-> (pulse_q & ~$past(fall)) == '0)
    else $error("command without falling edge");
  // Mode gating
  chk_periph_no_cmd: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode == ECIO_MODE_PERIPH) |=> pulse_q == '0)
    else $error("command in peripheral mode");
  chk_disabled_no_cmd: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode == ECIO_MODE_DISABLED) |=> pulse_q == '0)
    else $error("command in disabled mode");
  chk_halt_no_cmd: assert property (
    @(posedge pclk) disable iff (!presetn)
    halt_q |=> pulse_q == '0)
    else $error("command while halted");
  chk_branch_seq_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    (func != FUNC_SEQ) |=> pulse_q[6:5] == 2'h0)
    else $error("branch outside sequence");
  chk_seq_needs_mode: assert property (
    @(posedge pclk) disable iff (!presetn)
    !seqlike |=> pulse_q[6:2] == 5'h0)
    else $error("sequence command in continuous");
  chk_periph_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    peripheral_control_mode == (mode == ECIO_MODE_PERIPH))
    else $error("peripheral flag wrong");
  chk_remote_live: assert property (
    @(posedge pclk) disable iff (!presetn)
    remote |-> !inputs_live)
    else $error("inputs live in remote");
  // Output switching
  chk_on_cmd: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pulse_d[1] && !pulse_d[0] && !sw_off && !any_fault && !halt_q) |=> out_on_q)
    else $error("on command ignored");
  chk_off_cmd: assert property (
    @(posedge pclk) disable iff (!presetn)
    pulse_d[0] |=> !out_on_q)
    else $error("off command ignored");
  chk_halt_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    halt_q |=> !out_on_q && !disp_q)
    else $error("output on while halted");
  chk_ctrl_fault_halts: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_ctrl |=> halt_q)
    else $error("control fault did not halt");
  chk_prot_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    any_fault |=> prot_q)
    else $error("protection not flagged");
  chk_prot_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!any_fault && !halt_q) |=> !prot_q)
    else $error("protection flagged without fault");
  chk_disp_stays_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !disp_q |=> !disp_q)
    else $error("display came back");
  // Status pins
  chk_stat_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$past(tick) |-> stat_out == $past(stat_out))
    else $error("status moved off tick");
  chk_prot_pol: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(tick) |-> stat_out.protect == ~($past(prot_q) ^ $past(pol)))
    else $error("protection pol");
  chk_busy_pol: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(tick) |-> stat_out.busy == ~($past(ctrl_q[CTRL_BUSY_BIT]) ^ $past(pol)))
    else $error("busy pol");
  chk_agc_pol: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(tick) |-> stat_out.agc_cal == ~($past(ctrl_q[CTRL_AGC_BIT]) ^ $past(pol)))
    else $error("calibration pol");
  chk_lim_pol: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(tick) |-> stat_out.limiter == ~($past(ctrl_q[CTRL_LIM_BIT]) ^ $past(pol)))
    else $error("limiter pol");
  chk_sync_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($past(tick) && !$past(seqlike)) |-> !stat_out.step_sync1 && !stat_out.step_sync2)
    else $error("step sync outside sequence");
  chk_sync_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($past(tick) && $past(seqlike)) |->
      {stat_out.step_sync2, stat_out.step_sync1} == $past(ctrl_q[CTRL_SYNC_LSB +: 2]))
    else $error("step sync level");
  chk_trig_pol: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(tick) |-> stat_out.trigger == ~($past(ctrl_q[CTRL_TRIG_BIT]) ^ $past(tpol)))
    else $error("trigger pol");
  // Recall target
  chk_recall_func: assert property (
    @(posedge pclk) disable iff (!presetn)
    pulse_d[7] |=> recall_func == $past(func))
    else $error("recall function");
  chk_recall_comp: assert property (
    @(posedge pclk) disable iff (!presetn)
    pulse_d[7] |=> recall_compile == $past(seqlike))
    else $error("recall compile");
  chk_recall_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pulse_d[7] |=> recall_mem == $past(recall_mem))
    else $error("recall target moved");
endmodule

// ==== inc/ecio_pkg.sv ====
package ecio_pkg;
  // APB register byte offsets
  localparam logic [11:0] ECIO_CTRL_OFF   = 12'h000;
  localparam logic [11:0] ECIO_STAT_OFF   = 12'h004;
  localparam logic [11:0] ECIO_CMD_OFF    = 12'h008;
  localparam logic [11:0] ECIO_INPUT_OFF  = 12'h00C;
  // Control register fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_POL_BIT   = 2;
  localparam int CTRL_TPOL_BIT  = 3;
  localparam int CTRL_REM_BIT   = 4;
  localparam int CTRL_AGC_BIT   = 5;
  localparam int CTRL_BUSY_BIT  = 6;
  localparam int CTRL_R100_BIT  = 7;
  localparam int CTRL_LIM_BIT   = 8;
  localparam int CTRL_FUNC_LSB  = 9;
  localparam int CTRL_SYNC_LSB  = 11;
  localparam int CTRL_TRIG_BIT  = 13;
  localparam int CTRL_WIDTH     = 14;
  // Reset values: mode disabled, negative polarities, 100 V range
  localparam logic [13:0] CTRL_RST = 14'h0080;
  // Tick period
  localparam int TICK_MS      = 10;
  localparam int CLK_MHZ      = 250;
  localparam int TICK_CYCLES  = TICK_MS * 1000 * CLK_MHZ;
  // Port modes
  typedef enum logic [1:0] {
    ECIO_MODE_DISABLED = 2'h0,
    ECIO_MODE_ENABLED  = 2'h1,
    ECIO_MODE_PERIPH   = 2'h2
  } ecio_mode_t;
  // Output functions
  localparam logic [1:0] FUNC_CONT = 2'h0;
  localparam logic [1:0] FUNC_SEQ  = 2'h1;
  localparam logic [1:0] FUNC_SIM  = 2'h2;
  // Control inputs, active falling edge
  typedef struct packed {
    logic peak_clear;
    logic recall;
    logic branch2;
    logic branch1;
    logic seq_hold;
    logic seq_stop;
    logic seq_start;
    logic out_on;
    logic out_off;
  } ecio_cmd_t;
  localparam int CMD_W = 9;
  // Status pins
  typedef struct packed {
    logic step_sync2;
    logic step_sync1;
    logic trigger;
    logic range;
    logic busy;
    logic agc_cal;
    logic limiter;
    logic protect;
    logic output_state;
  } ecio_stat_t;
endpackage

// ==== tb/ecio_ext_ctrl.sv ====
`timescale 1ns/1ps
module ecio_ext_ctrl (
  // Requests from the bench, high pulls a pin low
  input  wire logic [8:0]      press,
  input  wire logic [1:0]      sel,
  // Control port pins
  output ecio_pkg::ecio_cmd_t  cmd_in_n,
  output logic [1:0]           mem_sel
);
  import ecio_pkg::*;
  // Released lines sit at the pull-up level, never at a stale low
  assign cmd_in_n = ecio_cmd_t'(~press);
  assign mem_sel  = sel;
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import ecio_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        fault_ovoc, fault_unit, fault_ctrl;
  ecio_cmd_t   cmd_in_n;
  ecio_stat_t  stat_out;
  logic [8:0]  press, cmd_pulse;
  logic [1:0]  sel, mem_sel, recall_mem, recall_func;
  logic        output_on, display_on, halted, peripheral_control_mode, recall_compile;
  int          err_count, compares, n0;
  int          pc [9];

  ecio_top #(.TICK_CYC(20)) ecio_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .fault_ovoc, .fault_unit, .fault_ctrl, .cmd_in_n, .mem_sel, .stat_out,
    .output_on, .display_on, .halted, .peripheral_control_mode, .cmd_pulse, .recall_mem, .recall_func,
    .recall_compile);
  ecio_ext_ctrl ecio_ext_ctrl_i (.press, .sel, .cmd_in_n, .mem_sel);

  always #2 pclk = ~pclk;
  // Count command pulses per input
  always @(posedge pclk) begin
    for (int i = 0; i < 9; i++) if (cmd_pulse[i] === 1'b1) pc[i]++;
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task settle;
    repeat (50) @(posedge pclk);
  endtask
  // Held low across two ticks on purpose: a level must not repeat
  task hit(input int b);
    n0 = pc[b];
    @(posedge pclk);
    press[b] <= 1'b1;
    settle;
    press[b] <= 1'b0;
    settle;
  endtask

  task t_reset;
    apb(1'b0, ECIO_CTRL_OFF, 32'h0);
    chk("ctrl", 32'h0080, rd);
    settle;
    chk("stat", 32'h3F, stat_out[5:0]);
    hit(1);
    chk("out_dis", 32'h0, output_on);
  endtask
  task t_onoff;
    apb(1'b1, ECIO_CTRL_OFF, 32'h81);
    hit(1);
    chk("out_on", 32'h1, output_on);
    chk("ostat", 32'h0, stat_out.output_state);
    hit(0);
    chk("out_off", 32'h0, output_on);
  endtask
  task t_pol;
    apb(1'b1, ECIO_CTRL_OFF, 32'hC5);
    settle;
    chk("stat_pos", 32'h30, stat_out[5:0]);
    apb(1'b1, ECIO_CTRL_OFF, 32'h41);
    settle;
    chk("stat_neg", 32'h0F, stat_out[5:0]);
    apb(1'b1, ECIO_CTRL_OFF, 32'h2001);
    settle;
    chk("trig", 32'h0, stat_out.trigger);
  endtask
  task t_block;
    apb(1'b1, ECIO_CTRL_OFF, 32'h91);
    hit(1);
    chk("out_rem", 32'h0, output_on);
    apb(1'b1, ECIO_CTRL_OFF, 32'h82);
    @(posedge pclk);
    chk("periph", 32'h1, peripheral_control_mode);
    hit(1);
    chk("out_per", 32'h0, output_on);
  endtask
  task t_seq;
    apb(1'b1, ECIO_CTRL_OFF, 32'h1A81);
    for (int b = 2; b < 7; b++) begin
      hit(b);
      chk("seq_pulse", 32'h1, pc[b] - n0);
    end
    chk("sync", 32'h3, {stat_out.step_sync2, stat_out.step_sync1});
    apb(1'b1, ECIO_CTRL_OFF, 32'h481);
    hit(2);
    chk("sim_start", 32'h1, pc[2] - n0);
    hit(5);
    chk("sim_branch", 32'h0, pc[5] - n0);
  endtask
  task t_recall;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, ECIO_CTRL_OFF, 32'h81 | ((s % 3) << 9));
      sel <= s[1:0];
      hit(7);
      chk("rmem", s, recall_mem);
      chk("rfunc", s % 3, recall_func);
      chk("rcomp", (s % 3) != 0, recall_compile);
    end
    hit(8);
    chk("peak", 32'h1, pc[8] - n0);
  endtask
  task t_fault;
    apb(1'b1, ECIO_CTRL_OFF, 32'h81);
    hit(1);
    fault_ovoc <= 1'b1;
    settle;
    chk("ovoc", 32'h0, {output_on, display_on});
    chk("prot", 32'h0, stat_out.protect);
    fault_ovoc <= 1'b0;
    hit(1);
    fault_unit <= 1'b1;
    settle;
    chk("unit", 32'h0, {output_on, display_on});
    fault_unit <= 1'b0;
    fault_ctrl <= 1'b1;
    settle;
    fault_ctrl <= 1'b0;
    hit(1);
    chk("halt", 32'h2, {halted, output_on});
  endtask
  task t_apb;
    apb(1'b1, 12'h010, 32'hFFFF);
    chk("werr", 32'h1, serr);
    apb(1'b0, 12'h010, 32'h0);
    chk("rerr", 32'h1, serr);
    chk("rdata0", 32'h0, rd);
  endtask

  task conclude;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, fault_ovoc, fault_unit, fault_ctrl} = '0;
    {paddr, pwdata, press, sel} = '0;
    pstrb = 4'hF;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_onoff;
    t_pol;
    t_block;
    t_seq;
    t_recall;
    t_apb;
    t_fault;
    conclude;
  end
  // About 2400 cycles expected; generous margin
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    conclude;
  end
endmodule
